// >>> pkg/gcs_pkg.sv
package gcs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] GCS_HDR_OFF  = 8'ha0;
    localparam logic [7:0] GCS_STAT_OFF = 8'ha4;

    // ----------------------------------------------------------------
    // Capability header fields
    // ----------------------------------------------------------------
    localparam int         GCS_MAJOR_LSB = 20;
    localparam int         GCS_MINOR_LSB = 16;
    localparam int         GCS_NEXT_LSB  = 8;
    localparam int         GCS_ID_LSB    = 0;
    localparam logic [3:0] GCS_MAJOR_REV = 4'h1;
    localparam logic [3:0] GCS_MINOR_REV = 4'h0;
    localparam logic [7:0] GCS_NEXT_PTR  = 8'h00;
    localparam logic [7:0] GCS_CAP_ID    = 8'h02;
    localparam logic [31:0] GCS_HDR_RESET = 32'h00100002;

    // ----------------------------------------------------------------
    // Status fields
    // ----------------------------------------------------------------
    localparam int         GCS_DEPTH_LSB  = 24;
    localparam int         GCS_SBA_BIT    = 9;
    localparam int         GCS_RATE_LSB   = 0;
    localparam logic [1:0] GCS_RATES      = 2'h3;
    localparam logic [7:0] GCS_DEPTH_RST  = 8'h1f;
    localparam logic [2:0] GCS_DEPTH_MAXC = 3'h5;
    localparam logic [31:0] GCS_STAT_RESET = 32'h1f000203;

endpackage : gcs_pkg

// >>> rtl/gcs_capability_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Header bits 23:20 read major revision 0001.
// - Header bits 19:16 read minor revision 0000.
// - Header bits 15:8 next pointer reads zero.
// - Header bits 7:0 read capability ID 02h.
// - Status depth low bits follow control 12:10.
// - Depth only 32,16,8,4,2,1; resets 1Fh.
// - Status bit 9 reads one, sideband supported.
// - Status bits 1:0 read 11b, 1X/2X.
// - Rate capability covers data and sideband buses.
module gcs_capability_regs
    import gcs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // Queue depth setting from the control register
    input  wire logic [2:0]        queueDepthSel
);

    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    // ----------------------------------------------------------------
    // Queue depth tracking
    // ----------------------------------------------------------------
    logic [7:0] queueDepth;
    logic [7:0] next_queueDepth;

    // Depth is held as depth minus one; codes past the last legal one
    // fall back to a depth of one rather than reporting a stray value.
    always_comb begin
        if (queueDepthSel <= GCS_DEPTH_MAXC) begin
            next_queueDepth = {2'h0, 6'(GCS_DEPTH_RST[5:0] >> queueDepthSel)};
        end else begin
            next_queueDepth = 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            queueDepth <= GCS_DEPTH_RST;
        end else begin
            queueDepth <= next_queueDepth;
        end
    end

    // ----------------------------------------------------------------
    // Register images
    // ----------------------------------------------------------------
    logic [31:0] hdrImage;
    logic [31:0] statImage;

    always_comb begin
        hdrImage = 32'h00000000;
        hdrImage[GCS_MAJOR_LSB +: 4] = GCS_MAJOR_REV;
        hdrImage[GCS_MINOR_LSB +: 4] = GCS_MINOR_REV;
        hdrImage[GCS_NEXT_LSB +: 8]  = GCS_NEXT_PTR;
        hdrImage[GCS_ID_LSB +: 8]    = GCS_CAP_ID;
    end

    // One rate field serves both the data bus and the sideband bus.
    always_comb begin
        statImage = 32'h00000000;
        statImage[GCS_DEPTH_LSB +: 8] = queueDepth;
        statImage[GCS_SBA_BIT]        = 1'b1;
        statImage[GCS_RATE_LSB +: 2]  = GCS_RATES;
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic setupPhase;
    logic hitHdr;
    logic hitStat;

    assign setupPhase = psel && !penable;
    assign hitHdr     = paddr[7:0] == GCS_HDR_OFF;
    assign hitStat    = paddr[7:0] == GCS_STAT_OFF;

    // The answer is prepared in the setup cycle so every access phase
    // completes in one cycle with registered outputs.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setupPhase;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= !(hitHdr || hitStat);
        end else begin
            pslverr <= 1'b0;
        end
    end

    // Writes to mapped registers complete without error and change nothing.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (setupPhase && !pwrite && hitHdr) begin
            prdata <= hdrImage;
        end else if (setupPhase && !pwrite && hitStat) begin
            prdata <= statImage;
        end else if (setupPhase) begin
            prdata <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_rd_hdr;
        psel && !penable && !pwrite && hitHdr;
    endsequence

    sequence s_rd_stat;
        psel && !penable && !pwrite && hitStat;
    endsequence

    a_hdr_major_rev: assert property (s_rd_hdr |=> pready && prdata[23:20] == 4'h1)
        else $error("Major revision field wrong");

    a_hdr_minor_rev: assert property (s_rd_hdr |=> prdata[19:16] == 4'h0)
        else $error("Minor revision field wrong");

    a_hdr_next_ptr: assert property (s_rd_hdr |=> prdata[15:8] == 8'h00)
        else $error("Next pointer not zero");

    a_hdr_cap_id: assert property (s_rd_hdr |=> prdata[7:0] == 8'h02 && !pslverr)
        else $error("Capability ID wrong");

    a_depth_follows_sel: assert property ((queueDepthSel == 3'h2) ##1 s_rd_stat
        |=> prdata[31:24] == 8'h07)
        else $error("Depth does not follow control setting");

    a_depth_legal_set: assert property (queueDepth == 8'h1f || queueDepth == 8'h0f
        || queueDepth == 8'h07 || queueDepth == 8'h03 || queueDepth == 8'h01
        || queueDepth == 8'h00)
        else $error("Depth outside legal set");

    a_stat_sba_bit: assert property (s_rd_stat |=> pready && prdata[9])
        else $error("Sideband support bit not set");

    a_stat_rates: assert property (s_rd_stat |=> prdata[1:0] == 2'h3)
        else $error("Rate field not 11b");

    a_reserved_zero: assert property (s_rd_stat |=> prdata[23:10] == 14'h0
        && prdata[8:2] == 7'h0 && !pslverr)
        else $error("Reserved status bits not zero");

    a_write_ignored: assert property (psel && !penable && pwrite && (hitHdr || hitStat)
        |=> pready && !pslverr && prdata == 32'h0)
        else $error("Mapped write not completed cleanly");

    a_hdr_reserved: assert property (s_rd_hdr |=> prdata[31:24] == 8'h00)
        else $error("Reserved header bits not zero");

    // ----------------------------------------------------------------
    // Protocol and depth checks
    // ----------------------------------------------------------------
    // These watch the answer timing as well as the read images, because
    // a slave that answers late would stall the bridge's config path.
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_wr_hdr;
        psel && !penable && pwrite && hitHdr;
    endsequence

    sequence s_wr_stat;
        psel && !penable && pwrite && hitStat;
    endsequence

    sequence s_rd_miss;
        psel && !penable && !pwrite && !hitHdr && !hitStat;
    endsequence

    sequence s_wr_miss;
        psel && !penable && pwrite && !hitHdr && !hitStat;
    endsequence

    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("No answer after setup cycle");

    a_ready_has_cause: assert property (pready |-> $past(setupPhase))
        else $error("Answer without a setup cycle");

    a_ready_one_cycle: assert property (pready && !setupPhase |=> !pready)
        else $error("Answer held too long");

    a_idle_no_ready: assert property (!psel |=> !pready)
        else $error("Answer while idle");

    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("Error flag without answer");

    a_err_only_miss: assert property (pslverr |-> $past(!hitHdr && !hitStat))
        else $error("Error on a mapped address");

    a_miss_read_err: assert property (s_rd_miss |=> pslverr && prdata == 32'h0)
        else $error("Unmapped read not refused");

    a_miss_write_err: assert property (s_wr_miss |=> pslverr && prdata == 32'h0)
        else $error("Unmapped write not refused");

    a_wr_hdr_clean: assert property (s_wr_hdr |=> !pslverr && prdata == 32'h0)
        else $error("Header write not ignored");

    a_wr_stat_clean: assert property (s_wr_stat |=> !pslverr && prdata == 32'h0)
        else $error("Status write not ignored");

    a_hdr_whole_word: assert property (s_rd_hdr |=> prdata == GCS_HDR_RESET)
        else $error("Header word wrong");

    a_hdr_no_err: assert property (s_rd_hdr |=> pready && !pslverr)
        else $error("Header read refused");

    a_hdr_id_upper: assert property (s_rd_hdr |=> prdata[7:2] == 6'h00)
        else $error("Capability ID upper bits set");

    a_stat_no_err: assert property (s_rd_stat |=> pready && !pslverr)
        else $error("Status read refused");

    a_stat_depth_live: assert property (s_rd_stat |=> prdata[31:24] == $past(queueDepth))
        else $error("Status depth not the held depth");

    a_stat_depth_top: assert property (s_rd_stat |=> prdata[31:30] == 2'h0)
        else $error("Depth upper bits not zero");

    a_stat_sba_only: assert property (s_rd_stat |=> prdata[9:8] == 2'h2)
        else $error("Sideband bit or neighbour wrong");

    a_stat_both_buses: assert property (s_rd_stat |=> prdata[0] && prdata[1])
        else $error("Rate capability not shared");

    a_depth_code0: assert property (queueDepthSel == 3'h0 |=> queueDepth == 8'h1f)
        else $error("Depth for code 0 wrong");

    a_depth_code1: assert property (queueDepthSel == 3'h1 |=> queueDepth == 8'h0f)
        else $error("Depth for code 1 wrong");

    a_depth_code2: assert property (queueDepthSel == 3'h2 |=> queueDepth == 8'h07)
        else $error("Depth for code 2 wrong");

    a_depth_code3: assert property (queueDepthSel == 3'h3 |=> queueDepth == 8'h03)
        else $error("Depth for code 3 wrong");

    a_depth_code4: assert property (queueDepthSel == 3'h4 |=> queueDepth == 8'h01)
        else $error("Depth for code 4 wrong");

    a_depth_code5: assert property (queueDepthSel == 3'h5 |=> queueDepth == 8'h00)
        else $error("Depth for code 5 wrong");

    // Codes past the last legal one must not invent a seventh depth.
    a_depth_clamp: assert property (queueDepthSel > 3'h5 |=> queueDepth == 8'h00)
        else $error("Illegal code not clamped");

    a_depth_top_read: assert property ((queueDepthSel == 3'h0) ##1 s_rd_stat
        |=> prdata[31:24] == 8'h1f)
        else $error("Deepest queue not reported");

    a_depth_clamp_read: assert property ((queueDepthSel > 3'h5) ##1 s_rd_stat
        |=> prdata[31:24] == 8'h00)
        else $error("Clamped depth not reported");

endmodule : gcs_capability_regs

`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gcs_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, a;
    logic [31:0] pwdata, prdata, seed;
    logic [2:0]  queueDepthSel;
    logic [32:0] expQ[$];
    int          errors, n_compared;

    gcs_capability_regs u_gcs_capability_regs (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .queueDepthSel(queueDepthSel));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // Depth is reported as depth minus one; codes above 5 are not legal depths.
    function automatic logic [7:0] depthOf(input logic [2:0] c);
        return (c < 3'h6) ? (8'h20 >> c) - 8'h01 : 8'h00;
    endfunction : depthOf

    task automatic tally_and_finish();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic compare(input logic [32:0] exp, input logic [32:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    // The request is held until pready is seen; the next setup may follow at once.
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [32:0] exp);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= seed;
        expQ.push_back(exp);
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            tally_and_finish();
        end
    endtask : apb

    // ------------------------------------------------------------
    // Clock, monitor and watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        forever begin
            @(posedge core_clk);
            if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
                compare(expQ.size() > 0 ? expQ.pop_front() : 33'hx, {pslverr, prdata});
            end
        end
    end

    initial begin
        repeat (3000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        {errors, n_compared} = '0;
        seed = 32'h3980710a;
        {resetn, psel, penable, pwrite, paddr, pwdata, queueDepthSel} = '0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        apb(1'b0, GCS_HDR_OFF, {1'b0, 32'h00100002});
        apb(1'b0, GCS_STAT_OFF, {1'b0, 32'h1f000203});
        apb(1'b1, GCS_STAT_OFF, 33'h0);
        apb(1'b0, 8'hac, {1'b1, 32'h0});
        for (int i = 0; i < 24; i++) begin
            seed = xorshift(seed);
            queueDepthSel <= (i < 8) ? i[2:0] : seed[2:0];
            psel    <= 1'b0;
            penable <= 1'b0;
            repeat (2) @(posedge core_clk);
            apb(1'b0, GCS_STAT_OFF, {1'b0, depthOf(queueDepthSel), 24'h000203});
            a = seed[12] ? GCS_HDR_OFF : seed[23:16];
            apb(1'b1, a, {a != GCS_HDR_OFF && a != GCS_STAT_OFF, 32'h0});
            apb(1'b0, GCS_HDR_OFF, {1'b0, 32'h00100002});
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge core_clk);
        // Mid-run reset: the first read after release must show the reset depth.
        queueDepthSel <= 3'h3;
        resetn        <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        apb(1'b0, GCS_STAT_OFF, {1'b0, GCS_STAT_RESET});
        apb(1'b0, GCS_STAT_OFF, {1'b0, 32'h03000203});
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge core_clk);
        if (expQ.size() != 0) begin
            errors++;
        end
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
